// ---- sim/wkt_checker.sv ----
// Port-level assertions for the wake-up timer unit.
// Assumes the single main clock and async reset of wkt_top.
module wkt_checker (
   input wire logic        mclk_i,
   input wire logic        arst_n_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        detect_done_i,
   input wire logic        card_found_i,
   input wire logic        wake_o,
   input wire logic        trim_start_o,
   input wire logic        card_detect_start_o,
   input wire logic        field_timer_start_o,
   input wire logic        power_down_req_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);

   a_field_with_detect: assert property (
      field_timer_start_o == card_detect_start_o)
      else $error("field timer start not paired with detect start");
   a_wake_one_pulse: assert property (wake_o |=> !wake_o)
      else $error("wake pulse longer than one cycle");
   a_trim_one_pulse: assert property (trim_start_o |=> !trim_start_o)
      else $error("trim start longer than one cycle");
   a_detect_one_pulse: assert property (
      card_detect_start_o |=> !card_detect_start_o)
      else $error("detect start longer than one cycle");
   a_pd_from_nocard: assert property (
      $rose(power_down_req_o) |-> $past(detect_done_i && !card_found_i))
      else $error("power-down request without a no-card result");
   a_pd_wake_clear: assert property (wake_o |=> !power_down_req_o)
      else $error("power-down request kept after wake");
   a_read_answer: assert property (
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_rdata_byte_only: assert property (
      s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
      else $error("read data above bit 7 not zero");
   a_write_answer: assert property (
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
      s_axi_wready_o |-> ##2 s_axi_bvalid_o)
      else $error("write answer not two cycles after take");

   c_wake: cover property (wake_o);
   c_pd: cover property ($rose(power_down_req_o));
   c_trim_detect: cover property (trim_start_o && card_detect_start_o);
endmodule

bind wkt_top wkt_checker u_chk (
   .mclk_i(mclk_i), .arst_n_i(arst_n_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rdata_o(s_axi_rdata_o), .detect_done_i(detect_done_i),
   .card_found_i(card_found_i), .wake_o(wake_o),
   .trim_start_o(trim_start_o), .card_detect_start_o(card_detect_start_o),
   .field_timer_start_o(field_timer_start_o),
   .power_down_req_o(power_down_req_o));

// ---- sim/wkt_top_tb.sv ----
// Self-checking bench for the wake-up timer unit.
// Assumes wkt_top with an AXI4-Lite slave on one 50 MHz clock.
module wkt_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] A_CT = wkt_pkg::WKT_ADDR_CTRL;
   localparam logic [7:0] A_RH = wkt_pkg::WKT_ADDR_RLH;
   localparam logic [7:0] A_RL = wkt_pkg::WKT_ADDR_RLL;
   localparam logic [7:0] A_CH = wkt_pkg::WKT_ADDR_CNTH;
   localparam logic [7:0] A_CL = wkt_pkg::WKT_ADDR_CNTL;
   localparam logic [7:0] A_ST = wkt_pkg::WKT_ADDR_STAT;
   localparam logic [7:0] A_MK = wkt_pkg::WKT_ADDR_MASK;
   logic        clk, rst_n, osc, awv, wv, bre, arv, rre, dd, cf;
   logic        awr, wr, bv, arr, rv, irq, wk, tr, cd, ft, pd;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd;
   logic [3:0]  ws, wsv;
   logic [1:0]  br, rr;
   logic [15:0] rv16;
   logic [33:0] exp_q[$];
   string       nm_q[$];
   int          err_count, n_checks, cyc, n_wk, n_tr, n_cd, n_ft;
   int          dv[4] = '{1, 8, 16, 32};
   logic [7:0]  ad[7] = '{A_CT, A_RH, A_RL, A_CH, A_CL, A_ST, A_MK};

   wkt_top uut (
      .mclk_i(clk), .arst_n_i(rst_n), .slow_osc_i(osc),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .detect_done_i(dd),
      .card_found_i(cf), .irq_o(irq), .wake_o(wk), .trim_start_o(tr),
      .card_detect_start_o(cd), .field_timer_start_o(ft),
      .power_down_req_o(pd));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cmp(input string n, input logic [33:0] e,
                      input logic [33:0] s);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   // Monitor side: results taken off the queue as they appear
   always @(posedge clk) begin
      if (rv && rre)
         cmp(nm_q.pop_front(), exp_q.pop_front(), {rr, rd});
      if (bv && bre)
         cmp(nm_q.pop_front(), exp_q.pop_front(), {br, 32'h0});
      if (wk === 1'b1) n_wk++;
      if (tr === 1'b1) n_tr++;
      if (cd === 1'b1) n_cd++;
      if (ft === 1'b1) n_ft++;
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end

   task automatic wb(input logic [7:0] a, input logic [7:0] d);
      exp_q.push_back({wkt_pkg::WKT_RESP_OKAY, 32'h0});
      nm_q.push_back("write response");
      awa <= a;
      wd <= {24'h0, d};
      ws <= wsv;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
      end while (bv !== 1'b1);
      bre <= 1'b0;
      @(posedge clk);
   endtask

   task automatic axr(input logic [7:0] a, input logic [33:0] e,
                      input string n);
      exp_q.push_back(e);
      nm_q.push_back(n);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rre <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rb(input logic [7:0] a, input logic [7:0] d,
                     input string n);
      axr(a, {wkt_pkg::WKT_RESP_OKAY, 24'h0, d}, n);
   endtask

   // Slow edges stand still between bursts
   task automatic pulse_osc(input int n);
      repeat (n) begin
         osc <= 1'b1;
         repeat (3) @(posedge clk);
         osc <= 1'b0;
         repeat (3) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask

   task automatic detect(input logic c);
      dd <= 1'b1;
      cf <= c;
      @(posedge clk);
      dd <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   initial begin
      {rst_n, osc, awv, wv, bre, arv, rre, dd, cf} = '0;
      {awa, ara, wd, ws, err_count, n_checks, cyc} = '0;
      {n_wk, n_tr, n_cd, n_ft} = '0;
      wsv = 4'h1;
      void'($urandom(32'h4c7f2078));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (ad[i]) rb(ad[i], 8'h00, "reset value");
      axr(8'h00, {wkt_pkg::WKT_RESP_SLVERR, 32'h0}, "unmapped");
      wb(A_CH, 8'h5a);
      rb(A_CH, 8'h00, "count hi");
      wsv = 4'h0;
      wb(A_RL, 8'h77);
      wsv = 4'h1;
      rb(A_RL, 8'h00, "reload lo");
      $display("test reset done");
      rv16 = 16'($urandom());
      wb(A_RH, rv16[15:8]);
      wb(A_RL, rv16[7:0]);
      wb(A_CT, 8'hc0);
      rb(A_CT, 8'h80, "ctrl");
      wb(A_RH, ~rv16[15:8]);
      wb(A_RL, ~rv16[7:0]);
      rb(A_CH, rv16[15:8], "count hi");
      rb(A_CL, rv16[7:0], "count lo");
      wb(A_CT, 8'h00);
      rb(A_CT, 8'h80, "ctrl");
      wb(A_CT, 8'h40);
      rb(A_CT, 8'h00, "ctrl");
      rb(A_CL, rv16[7:0], "count lo");
      $display("test start stop done");
      wb(A_RH, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wb(A_RL, 8'h05);
         wb(A_CT, 8'hc0 | 8'(i));
         rb(A_CT, 8'h80 | 8'(i), "ctrl");
         pulse_osc(dv[i] - 1);
         rb(A_CL, 8'h05, "count lo");
         pulse_osc(1);
         rb(A_CL, 8'h04, "count lo");
      end
      $display("test tick source done");
      wb(A_ST, 8'h07);
      wb(A_RL, 8'h02);
      wb(A_CT, 8'hc0);
      pulse_osc(2);
      rb(A_CT, 8'h00, "ctrl");
      rb(A_CL, 8'h00, "count lo");
      rb(A_ST, 8'h01, "status");
      cmp("irq", 34'(1'b0), 34'(irq));
      wb(A_MK, 8'h01);
      cmp("irq", 34'(1'b1), 34'(irq));
      wb(A_ST, 8'h01);
      cmp("irq", 34'(1'b0), 34'(irq));
      wb(A_CT, 8'hc8);
      pulse_osc(2);
      rb(A_CT, 8'h88, "ctrl");
      rb(A_CL, 8'h02, "count lo");
      cmp("irq", 34'(1'b1), 34'(irq));
      $display("test underflow done");
      wb(A_CT, 8'h40);
      wb(A_ST, 8'h07);
      wb(A_MK, 8'h07);
      wb(A_RL, 8'h01);
      {n_wk, n_tr, n_cd, n_ft} = '0;
      wb(A_CT, 8'hf4);
      pulse_osc(1);
      rb(A_CT, 8'hb4, "ctrl");
      rb(A_CL, 8'h01, "count lo");
      detect(1'b0);
      cmp("power down", 34'(1'b1), 34'(pd));
      rb(A_ST, 8'h05, "status");
      pulse_osc(1);
      cmp("power down", 34'(1'b0), 34'(pd));
      wb(A_ST, 8'h05);
      cmp("irq", 34'(1'b0), 34'(irq));
      detect(1'b1);
      cmp("power down", 34'(1'b0), 34'(pd));
      rb(A_ST, 8'h02, "status");
      cmp("irq", 34'(1'b1), 34'(irq));
      cmp("trim pulses", 34'(2), 34'(n_tr));
      cmp("detect pulses", 34'(2), 34'(n_cd));
      cmp("field pulses", 34'(2), 34'(n_ft));
      cmp("wake pulses", 34'(2), 34'(n_wk));
      $display("test auto functions done");
      conclude();
   end
endmodule

// ---- verilog/wkt_pkg.sv ----
// Constants and types for the wake-up timer unit.
// Assumes a 32-bit AXI4-Lite slave with 8-bit byte addresses.
package wkt_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] WKT_IDX_CTRL = 8'h23;
   localparam logic [7:0] WKT_IDX_RLH  = 8'h24;
   localparam logic [7:0] WKT_IDX_RLL  = 8'h25;
   localparam logic [7:0] WKT_IDX_CNTH = 8'h26;
   localparam logic [7:0] WKT_IDX_CNTL = 8'h27;
   localparam logic [7:0] WKT_IDX_STAT = 8'h30;
   localparam logic [7:0] WKT_IDX_MASK = 8'h31;
   localparam logic [7:0] WKT_ADDR_CTRL = {WKT_IDX_CTRL[5:0], 2'h0};
   localparam logic [7:0] WKT_ADDR_RLH  = {WKT_IDX_RLH[5:0], 2'h0};
   localparam logic [7:0] WKT_ADDR_RLL  = {WKT_IDX_RLL[5:0], 2'h0};
   localparam logic [7:0] WKT_ADDR_CNTH = {WKT_IDX_CNTH[5:0], 2'h0};
   localparam logic [7:0] WKT_ADDR_CNTL = {WKT_IDX_CNTL[5:0], 2'h0};
   localparam logic [7:0] WKT_ADDR_STAT = {WKT_IDX_STAT[5:0], 2'h0};
   localparam logic [7:0] WKT_ADDR_MASK = {WKT_IDX_MASK[5:0], 2'h0};

   // Control register fields
   localparam int WKT_BIT_RUN  = 7;
   localparam int WKT_BIT_QUAL = 6;
   localparam int WKT_BIT_TRIM = 5;
   localparam int WKT_BIT_CD   = 4;
   localparam int WKT_BIT_RST  = 3;
   localparam int WKT_BIT_WAKE = 2;

   // Status and mask fields
   localparam int WKT_ST_UFL    = 0;
   localparam int WKT_ST_CARD   = 1;
   localparam int WKT_ST_NOCARD = 2;
   localparam int WKT_ST_W      = 3;

   // Values after reset; last count before underflow
   localparam logic [5:0]  WKT_CFG_RST    = 6'h00;
   localparam logic [15:0] WKT_RELOAD_RST = 16'h0000;
   localparam logic [15:0] WKT_COUNT_RST  = 16'h0000;
   localparam logic [2:0]  WKT_MASK_RST   = 3'h0;
   localparam logic [15:0] WKT_CNT_LAST   = 16'h0001;

   // Prescaler terminal counts
   localparam logic [4:0] WKT_TC_DIV1  = 5'h00;
   localparam logic [4:0] WKT_TC_DIV8  = 5'h07;
   localparam logic [4:0] WKT_TC_DIV16 = 5'h0f;
   localparam logic [4:0] WKT_TC_DIV32 = 5'h1f;

   localparam logic [1:0] WKT_RESP_OKAY   = 2'h0;
   localparam logic [1:0] WKT_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WKT_SEL_DIV1  = 2'h0,
      WKT_SEL_DIV8  = 2'h1,
      WKT_SEL_DIV16 = 2'h2,
      WKT_SEL_DIV32 = 2'h3
   } wkt_tick_sel_t;

   typedef enum logic {
      WKT_CD_IDLE = 1'b0,
      WKT_CD_WAIT = 1'b1
   } wkt_cd_state_t;
endpackage

// ---- verilog/wkt_tick_gen.sv ----
// Slow oscillator synchroniser and tick prescaler.
// Assumes the slow oscillator is far slower than the main clock.
module wkt_tick_gen (
   input  wire logic  mclk_i,
   input  wire logic  arst_n_i,
   input  wire logic  slow_osc_i,
   wkt_tick_if.gen    tk
);
   logic       sync1_r;
   logic       sync2_r;
   logic       prev_r;
   logic [4:0] div_r;
   logic [4:0] div_nxt;
   logic       tick_r;
   logic       tick_nxt;
   logic [4:0] tc;
   logic       rise;

   always_comb begin
      rise     = sync2_r & ~prev_r;
      div_nxt  = div_r;
      tick_nxt = 1'b0;
      unique case (tk.sel)
         wkt_pkg::WKT_SEL_DIV1:  tc = wkt_pkg::WKT_TC_DIV1;
         wkt_pkg::WKT_SEL_DIV8:  tc = wkt_pkg::WKT_TC_DIV8;
         wkt_pkg::WKT_SEL_DIV16: tc = wkt_pkg::WKT_TC_DIV16;
         wkt_pkg::WKT_SEL_DIV32: tc = wkt_pkg::WKT_TC_DIV32;
      endcase
      // Held in reset while stopped so each start sees a full period
      if (!tk.run) begin
         div_nxt = 5'h00;
      end else if (rise) begin
         if (div_r == tc) begin
            div_nxt  = 5'h00;
            tick_nxt = 1'b1;
         end else begin
            div_nxt = div_r + 5'h01;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
         div_r   <= 5'h00;
         tick_r  <= 1'b0;
      end else begin
         sync1_r <= slow_osc_i;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
         div_r   <= div_nxt;
         tick_r  <= tick_nxt;
      end
   end

   assign tk.tick = tick_r;
endmodule

// ---- verilog/wkt_tick_if.sv ----
// Tick request and tick pulse between timer core and prescaler.
// Both ends run on the same main clock.
interface wkt_tick_if;
   logic                  run;
   wkt_pkg::wkt_tick_sel_t sel;
   logic                  tick;
   modport ctrl (output run, output sel, input tick);
   modport gen  (input run, input sel, output tick);
endinterface

// ---- verilog/wkt_top.sv ----
// Wake-up timer unit: 16-bit down counter with AXI4-Lite registers.
// Assumes detection results arrive on the main clock.
//
// What this block does
// - Running bit shows counting state
// - Run change only with qualifier bit
// - Auto trim starts trimming on underflow
// - Auto detect launches card detection
// - Card found: interrupt, stay active
// - No card: back to power-down if wake bit set
// - Detection mode reloads without gap
// - Field-on time timed by timer three
// - Auto restart or detection mode reloads, otherwise stops
// - Every underflow sets interrupt flag
// - Auto wake leaves power-down on underflow
// - Tick source: undivided, /8, /16, /32
// - Reload loaded only at start or on restart/detection underflow
// - Live count readable as two bytes
module wkt_top (
   input  wire logic        mclk_i,
   input  wire logic        arst_n_i,
   input  wire logic        slow_osc_i,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic        detect_done_i,
   input  wire logic        card_found_i,
   output logic             irq_o,
   output logic             wake_o,
   output logic             trim_start_o,
   output logic             card_detect_start_o,
   output logic             field_timer_start_o,
   output logic             power_down_req_o
);
   wkt_tick_if tick_bus ();

   // Bus state
   logic        aw_full_r,  aw_full_nxt;
   logic        w_full_r,   w_full_nxt;
   logic [7:0]  awaddr_r,   awaddr_nxt;
   logic [7:0]  wbyte_r,    wbyte_nxt;
   logic        wlane_r,    wlane_nxt;
   logic        awrdy_r,    awrdy_nxt;
   logic        wrdy_r,     wrdy_nxt;
   logic        bvalid_r,   bvalid_nxt;
   logic [1:0]  bresp_r,    bresp_nxt;
   logic        arrdy_r,    arrdy_nxt;
   logic        rvalid_r,   rvalid_nxt;
   logic [31:0] rdata_r,    rdata_nxt;
   logic [1:0]  rresp_r,    rresp_nxt;
   logic        do_write;

   // Timer state
   logic [5:0]  cfg_r,      cfg_nxt;
   logic        running_r,  running_nxt;
   logic [15:0] reload_r,   reload_nxt;
   logic [15:0] count_r,    count_nxt;
   logic [2:0]  status_r,   status_nxt;
   logic [2:0]  mask_r,     mask_nxt;
   logic        irq_r,      irq_nxt;
   logic        wake_r,     wake_nxt;
   logic        trim_r,     trim_nxt;
   logic        cd_r,       cd_nxt;
   logic        field_r,    field_nxt;
   logic        pd_r,       pd_nxt;
   wkt_pkg::wkt_cd_state_t cd_st_r, cd_st_nxt;
   logic [2:0]  st_set;
   logic [2:0]  st_clr;
   logic        ufl;
   logic        wr_ctrl;

   assign tick_bus.run = running_r;
   assign tick_bus.sel = wkt_pkg::wkt_tick_sel_t'(cfg_r[1:0]);

   // Slow oscillator synchroniser and prescaler
   wkt_tick_gen u_tick_gen (
      .mclk_i     (mclk_i),
      .arst_n_i   (arst_n_i),
      .slow_osc_i (slow_osc_i),
      .tk         (tick_bus)
   );

   // AXI4-Lite write and read channels
   // Only byte lane 0 is stored; upper lanes are dropped
   always_comb begin
      aw_full_nxt = aw_full_r;
      w_full_nxt  = w_full_r;
      awaddr_nxt  = awaddr_r;
      wbyte_nxt   = wbyte_r;
      wlane_nxt   = wlane_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      arrdy_nxt   = arrdy_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      do_write    = aw_full_r & w_full_r & ~bvalid_r;
      if (s_axi_awvalid_i && awrdy_r) begin
         aw_full_nxt = 1'b1;
         awaddr_nxt  = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wrdy_r) begin
         w_full_nxt = 1'b1;
         wbyte_nxt  = s_axi_wdata_i[7:0];
         wlane_nxt  = s_axi_wstrb_i[0];
      end
      if (bvalid_r && s_axi_bready_i) begin
         bvalid_nxt = 1'b0;
      end
      if (do_write) begin
         aw_full_nxt = 1'b0;
         w_full_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         unique case (awaddr_r)
            wkt_pkg::WKT_ADDR_CTRL, wkt_pkg::WKT_ADDR_RLH,
            wkt_pkg::WKT_ADDR_RLL,  wkt_pkg::WKT_ADDR_CNTH,
            wkt_pkg::WKT_ADDR_CNTL, wkt_pkg::WKT_ADDR_STAT,
            wkt_pkg::WKT_ADDR_MASK: bresp_nxt = wkt_pkg::WKT_RESP_OKAY;
            default:                bresp_nxt = wkt_pkg::WKT_RESP_SLVERR;
         endcase
      end
      awrdy_nxt = ~aw_full_nxt;
      wrdy_nxt  = ~w_full_nxt;

      if (rvalid_r && s_axi_rready_i) begin
         rvalid_nxt = 1'b0;
         arrdy_nxt  = 1'b1;
      end
      if (s_axi_arvalid_i && arrdy_r) begin
         arrdy_nxt  = 1'b0;
         rvalid_nxt = 1'b1;
         rdata_nxt  = 32'h0000_0000;
         rresp_nxt  = wkt_pkg::WKT_RESP_OKAY;
         unique case (s_axi_araddr_i)
            // running bit readback; qualifier reads zero
            wkt_pkg::WKT_ADDR_CTRL: rdata_nxt[7:0] = {running_r, 1'b0,
                                                      cfg_r};
            wkt_pkg::WKT_ADDR_RLH:  rdata_nxt[7:0] = reload_r[15:8];
            wkt_pkg::WKT_ADDR_RLL:  rdata_nxt[7:0] = reload_r[7:0];
            // live count bytes
            // Bytes are not latched together, so reads may tear
            wkt_pkg::WKT_ADDR_CNTH: rdata_nxt[7:0] = count_r[15:8];
            wkt_pkg::WKT_ADDR_CNTL: rdata_nxt[7:0] = count_r[7:0];
            wkt_pkg::WKT_ADDR_STAT: rdata_nxt[2:0] = status_r;
            wkt_pkg::WKT_ADDR_MASK: rdata_nxt[2:0] = mask_r;
            default:                rresp_nxt = wkt_pkg::WKT_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wbyte_r   <= 8'h00;
         wlane_r   <= 1'b0;
         awrdy_r   <= 1'b1;
         wrdy_r    <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= wkt_pkg::WKT_RESP_OKAY;
         arrdy_r   <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= wkt_pkg::WKT_RESP_OKAY;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r  <= w_full_nxt;
         awaddr_r  <= awaddr_nxt;
         wbyte_r   <= wbyte_nxt;
         wlane_r   <= wlane_nxt;
         awrdy_r   <= awrdy_nxt;
         wrdy_r    <= wrdy_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         arrdy_r   <= arrdy_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   // Timer core, register writes and events
   always_comb begin
      cfg_nxt     = cfg_r;
      running_nxt = running_r;
      reload_nxt  = reload_r;
      count_nxt   = count_r;
      mask_nxt    = mask_r;
      cd_st_nxt   = cd_st_r;
      pd_nxt      = pd_r;
      st_set      = 3'h0;
      st_clr      = 3'h0;
      wr_ctrl     = do_write & wlane_r & (awaddr_r == wkt_pkg::WKT_ADDR_CTRL);
      // underflow is the step that reaches zero
      ufl = running_r & tick_bus.tick & (count_r <= wkt_pkg::WKT_CNT_LAST);

      if (running_r && tick_bus.tick) begin
         if (ufl) begin
            // reload on restart or detection mode
            if (cfg_r[wkt_pkg::WKT_BIT_RST] ||
                cfg_r[wkt_pkg::WKT_BIT_CD]) begin
               count_nxt = reload_r;
            end else begin
               count_nxt   = 16'h0000;
               running_nxt = 1'b0;
            end
         end else begin
            count_nxt = count_r - 16'h0001;
         end
      end

      st_set[wkt_pkg::WKT_ST_UFL] = ufl;
      trim_nxt  = ufl & cfg_r[wkt_pkg::WKT_BIT_TRIM];
      cd_nxt    = ufl & cfg_r[wkt_pkg::WKT_BIT_CD];
      // field time handed to timer three
      field_nxt = ufl & cfg_r[wkt_pkg::WKT_BIT_CD];
      wake_nxt  = ufl & cfg_r[wkt_pkg::WKT_BIT_WAKE];
      if (wake_nxt) begin
         pd_nxt = 1'b0;
      end

      // Results with no detection pending are ignored
      if (cd_nxt) begin
         cd_st_nxt = wkt_pkg::WKT_CD_WAIT;
      end else begin
         unique case (cd_st_r)
            wkt_pkg::WKT_CD_IDLE: cd_st_nxt = wkt_pkg::WKT_CD_IDLE;
            wkt_pkg::WKT_CD_WAIT: begin
               if (detect_done_i) begin
                  cd_st_nxt = wkt_pkg::WKT_CD_IDLE;
                  if (card_found_i) begin
                     st_set[wkt_pkg::WKT_ST_CARD] = 1'b1;
                     pd_nxt = 1'b0;
                  end else begin
                     // no card: power-down if wake bit set
                     st_set[wkt_pkg::WKT_ST_NOCARD] = 1'b1;
                     if (cfg_r[wkt_pkg::WKT_BIT_WAKE]) begin
                        pd_nxt = 1'b1;
                     end
                  end
               end
            end
         endcase
      end

      if (wr_ctrl) begin
         cfg_nxt = wbyte_r[5:0];
         if (wbyte_r[wkt_pkg::WKT_BIT_QUAL]) begin
            running_nxt = wbyte_r[wkt_pkg::WKT_BIT_RUN];
            if (wbyte_r[wkt_pkg::WKT_BIT_RUN]) begin
               count_nxt = reload_r;
            end
         end
      end
      if (do_write && wlane_r) begin
         unique case (awaddr_r)
            wkt_pkg::WKT_ADDR_RLH:  reload_nxt[15:8] = wbyte_r;
            wkt_pkg::WKT_ADDR_RLL:  reload_nxt[7:0]  = wbyte_r;
            wkt_pkg::WKT_ADDR_STAT: st_clr = wbyte_r[2:0];
            wkt_pkg::WKT_ADDR_MASK: mask_nxt = wbyte_r[2:0];
            default:                st_clr = 3'h0;
         endcase
      end

      // New events win over a clear in the same cycle
      status_nxt = (status_r & ~st_clr) | st_set;
      irq_nxt    = |(status_nxt & mask_nxt);
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_r     <= wkt_pkg::WKT_CFG_RST;
         running_r <= 1'b0;
         reload_r  <= wkt_pkg::WKT_RELOAD_RST;
         count_r   <= wkt_pkg::WKT_COUNT_RST;
         status_r  <= 3'h0;
         mask_r    <= wkt_pkg::WKT_MASK_RST;
         irq_r     <= 1'b0;
         wake_r    <= 1'b0;
         trim_r    <= 1'b0;
         cd_r      <= 1'b0;
         field_r   <= 1'b0;
         pd_r      <= 1'b0;
         cd_st_r   <= wkt_pkg::WKT_CD_IDLE;
      end else begin
         cfg_r     <= cfg_nxt;
         running_r <= running_nxt;
         reload_r  <= reload_nxt;
         count_r   <= count_nxt;
         status_r  <= status_nxt;
         mask_r    <= mask_nxt;
         irq_r     <= irq_nxt;
         wake_r    <= wake_nxt;
         trim_r    <= trim_nxt;
         cd_r      <= cd_nxt;
         field_r   <= field_nxt;
         pd_r      <= pd_nxt;
         cd_st_r   <= cd_st_nxt;
      end
   end

   assign s_axi_awready_o     = awrdy_r;
   assign s_axi_wready_o      = wrdy_r;
   assign s_axi_bresp_o       = bresp_r;
   assign s_axi_bvalid_o      = bvalid_r;
   assign s_axi_arready_o     = arrdy_r;
   assign s_axi_rdata_o       = rdata_r;
   assign s_axi_rresp_o       = rresp_r;
   assign s_axi_rvalid_o      = rvalid_r;
   assign irq_o               = irq_r;
   assign wake_o              = wake_r;
   assign trim_start_o        = trim_r;
   assign card_detect_start_o = cd_r;
   assign field_timer_start_o = field_r;
   assign power_down_req_o    = pd_r;
endmodule
